// file: nvm_ctrl_regs.svh
// Register offsets, field positions and timing constants of the serial memory controller
`ifndef NVM_CTRL_REGS_SVH
`define NVM_CTRL_REGS_SVH

// ---------------------------------------------------------------------------
// Register map (byte addresses)
// ---------------------------------------------------------------------------
`define NVM_CMD_OFS      8'h00
`define NVM_DATA_OFS     8'h04
`define NVM_SAL_OFS      8'h08
`define NVM_SAH_OFS      8'h0C
`define NVM_PINCFG_OFS   8'h10

// ---------------------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------------------
`define NVM_BUSY_BIT     31
`define NVM_OP_MSB       30
`define NVM_OP_LSB       28
`define NVM_TO_BIT       9
`define NVM_LOADED_BIT   8
`define NVM_LOC_MSB      6
`define NVM_PIN_DIS_BIT  0
`define NVM_PIN_GPD_BIT  1
`define NVM_PIN_GPC_BIT  2
`define NVM_PIN_MON_BIT  3

// ---------------------------------------------------------------------------
// Memory protocol
// ---------------------------------------------------------------------------
`define NVM_SIGNATURE    8'hA5
`define NVM_SIG_LOC      3'h0
`define NVM_ADDR_BYTES   3'h6
`define NVM_LEN_SHORT    5'h0a
`define NVM_LEN_LONG     5'h12
`define NVM_HDR_BITS     5'h0a
`define NVM_SOP_MISC     2'h0
`define NVM_SOP_WRITE    2'h1
`define NVM_SOP_READ     2'h2
`define NVM_SOP_ERASE    2'h3
`define NVM_SUB_LOCK     7'h00
`define NVM_SUB_FILL     7'h20
`define NVM_SUB_WIPE     7'h40
`define NVM_SUB_UNLOCK   7'h60

// ---------------------------------------------------------------------------
// Timing
// ---------------------------------------------------------------------------
`define NVM_CLK_MHZ      200
`define NVM_SK_HALF_NS   500
`define NVM_SK_HALF_CYC  ((`NVM_SK_HALF_NS * `NVM_CLK_MHZ + 999) / 1000)
`define NVM_TIMEOUT_MS   30
`define NVM_TIMEOUT_CYC  (`NVM_TIMEOUT_MS * 1000 * `NVM_CLK_MHZ)
`define NVM_POLL_SETTLE  23'h00_0004

`endif

// file: nvm_pkg.sv
// Types shared by the serial memory controller
package nvm_pkg;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,
    ST_SHIFT = 3'h1,
    ST_NEXT  = 3'h3,
    ST_GAP   = 3'h2,
    ST_POLL  = 3'h6
  } nvm_state_e;

  typedef enum logic [2:0] {
    OP_READ   = 3'h0,
    OP_LOCK   = 3'h1,
    OP_UNLOCK = 3'h2,
    OP_WRITE  = 3'h3,
    OP_FILL   = 3'h4,
    OP_ERASE  = 3'h5,
    OP_WIPE   = 3'h6,
    OP_RELOAD = 3'h7
  } nvm_op_e;

endpackage

// file: nvm_sync2.sv
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module nvm_sync2 #(
  parameter int W = 1
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] meta;

  // First stage feeds only the second stage
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta <= '0;
      q_o  <= '0;
    end else begin
      meta <= d_i;
      q_o  <= meta;
    end
  end
endmodule // nvm_sync2

// file: nvm_serial_shift.sv
// Serial bit engine: clocks a command word out and shifts answer bits in
`timescale 1ns/1ps
`include "nvm_ctrl_regs.svh"
module nvm_serial_shift (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        start_i,
  input  wire logic [4:0]  nbits_i,
  input  wire logic [17:0] word_i,
  input  wire logic        din_i,
  output logic             done_o,
  output logic             active_o,
  output logic             sk_o,
  output logic             dout_o,
  output logic             doe_o,
  output logic [7:0]       rx_o
);
  localparam int unsigned HALF = `NVM_SK_HALF_CYC;

  logic [7:0]  div;
  logic [17:0] sh;
  logic [4:0]  left;
  logic [4:0]  sent;
  logic [4:0]  nb;
  logic [4:0]  rises;
  logic        tick;

  assign tick   = active_o && (div == 8'(HALF - 1));
  assign dout_o = sh[17];
  // Release the shared data pin once the header is out, so the memory can answer
  assign doe_o  = active_o && (sent < `NVM_HDR_BITS);

  always_ff @(posedge clk_i) begin
    if (rst_i || !active_o || tick) begin
      div <= 8'h00;
    end else begin
      div <= div + 8'h01;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      active_o <= 1'b0;
      done_o   <= 1'b0;
      sk_o     <= 1'b0;
      sh       <= 18'h0_0000;
      left     <= 5'h00;
      sent     <= 5'h00;
      nb       <= 5'h00;
      rx_o     <= 8'h00;
    end else begin
      done_o <= 1'b0;
      if (start_i && !active_o) begin
        active_o <= 1'b1;
        sh       <= word_i;
        left     <= nbits_i;
        nb       <= nbits_i;
        sent     <= 5'h00;
        sk_o     <= 1'b0;
      end else if (tick) begin
        if (!sk_o) begin
          sk_o <= 1'b1;
          rx_o <= {rx_o[6:0], din_i};
        end else begin
          sk_o <= 1'b0;
          sent <= sent + 5'h01;
          if (left == 5'h01) begin
            active_o <= 1'b0;
            done_o   <= 1'b1;
          end else begin
            left <= left - 5'h01;
            sh   <= {sh[16:0], 1'b0};
          end
        end
      end
    end
  end

  // Helper: count serial clock rises of one transaction
  always_ff @(posedge clk_i) begin
    if (rst_i || (start_i && !active_o)) begin
      rises <= 5'h00;
    end else if (tick && !sk_o) begin
      rises <= rises + 5'h01;
    end
  end

  a_clock_count: assert property (@(posedge clk_i) disable iff (rst_i)
    done_o |-> (rises == nb) && !sk_o)
    else $error("serial clock count differs from transaction length");
endmodule // nvm_serial_shift

// file: nvm_ctrl.sv
// Serial memory controller: station address load, host commands, bus registers
//
// The placing of the registers and register access over Wishbone were decided locally.
`timescale 1ns/1ps
`include "nvm_ctrl_regs.svh"
module nvm_ctrl #(
  parameter int unsigned TIMEOUT_CYC = `NVM_TIMEOUT_CYC
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  output logic             serial_mem_select_o,
  output logic             serial_mem_clock_pin_o,
  output logic             serial_mem_data_pin_o,
  output logic             serial_mem_data_pin_oe_o,
  input  wire logic        serial_mem_data_pin_i,
  input  wire logic [1:0]  mii_mon_i,
  output logic      [47:0] station_addr_o
);
  localparam int unsigned HALF = `NVM_SK_HALF_CYC;

  // ---------------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------------
  function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  sel);
    for (int i = 0; i < 4; i++) begin
      lane_merge[8*i +: 8] = sel[i] ? new_v[8*i +: 8] : old_v[8*i +: 8];
    end
  endfunction

  // Returns {length, left-aligned word}: start bit, opcode, 7-bit location, data
  function automatic logic [22:0] build_word(input nvm_pkg::nvm_op_e op,
                                             input logic [6:0]       loc,
                                             input logic [7:0]       dat);
    case (op)
      nvm_pkg::OP_READ:  build_word = {`NVM_LEN_LONG, 1'b1, `NVM_SOP_READ, loc, 8'h00};
      nvm_pkg::OP_WRITE: build_word = {`NVM_LEN_LONG, 1'b1, `NVM_SOP_WRITE, loc, dat};
      nvm_pkg::OP_FILL:  build_word = {`NVM_LEN_LONG, 1'b1, `NVM_SOP_MISC, `NVM_SUB_FILL, dat};
      nvm_pkg::OP_ERASE: build_word = {`NVM_LEN_SHORT, 1'b1, `NVM_SOP_ERASE, loc, 8'h00};
      nvm_pkg::OP_WIPE:  build_word = {`NVM_LEN_SHORT, 1'b1, `NVM_SOP_MISC, `NVM_SUB_WIPE, 8'h00};
      nvm_pkg::OP_UNLOCK: build_word = {`NVM_LEN_SHORT, 1'b1, `NVM_SOP_MISC, `NVM_SUB_UNLOCK, 8'h00};
      default:           build_word = {`NVM_LEN_SHORT, 1'b1, `NVM_SOP_MISC, `NVM_SUB_LOCK, 8'h00};
    endcase
  endfunction

  // ---------------------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------------------
  nvm_pkg::nvm_state_e state;
  nvm_pkg::nvm_op_e    cmd_op;
  nvm_pkg::nvm_op_e    sh_op;
  logic [6:0]          cmd_loc;
  logic [6:0]          sh_loc;
  logic                cmd_busy;
  logic                busy_view;
  logic                to_flag;
  logic                loaded;
  logic                loading;
  logic                boot;
  logic [2:0]          idx;
  logic [7:0]          data;
  logic [31:0]         sal;
  logic [15:0]         sah;
  logic [3:0]          pincfg;
  logic [22:0]         tcnt;
  logic                gap_end;
  logic [2:0]          sync_q;
  logic                din_s;
  logic [1:0]          mon_s;
  logic                req;
  logic                wr;
  logic                cmd_wr;
  logic                host_start;
  logic [31:0]         cmd_view;
  logic [31:0]         nw;
  logic [31:0]         next_rdata;
  logic                sh_start;
  logic [22:0]         sh_pack;
  logic                sh_done;
  logic                sh_active;
  logic                sh_sk;
  logic                sh_dout;
  logic                sh_doe;
  logic [7:0]          rx;
  logic                self_timed;
  logic [31:0]         sah_merged;

  nvm_sync2 #(.W(3)) u_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   ({mii_mon_i, serial_mem_data_pin_i}),
    .q_o   (sync_q)
  );
  assign din_s = sync_q[0];
  assign mon_s = sync_q[2:1];

  // ---------------------------------------------------------------------------
  // Bus slave
  // ---------------------------------------------------------------------------
  assign req        = wb_cyc_i && wb_stb_i;
  assign wr         = req && wb_we_i && wb_ack_o;
  assign cmd_wr     = wr && (wb_adr_i == `NVM_CMD_OFS);
  assign busy_view  = cmd_busy || boot;
  assign cmd_view   = {busy_view, cmd_op, 18'h0_0000, to_flag, loaded, 1'b0, cmd_loc};
  assign nw         = lane_merge(cmd_view, wb_dat_i, wb_sel_i);
  // Command and data writes during start-up or a running operation are dropped
  assign host_start = cmd_wr && !busy_view && nw[`NVM_BUSY_BIT];

  always_comb begin
    if (wb_adr_i == `NVM_CMD_OFS) begin
      next_rdata = cmd_view;
    end else if (wb_adr_i == `NVM_DATA_OFS) begin
      next_rdata = {24'h00_0000, data};
    end else if (wb_adr_i == `NVM_SAL_OFS) begin
      next_rdata = sal;
    end else if (wb_adr_i == `NVM_SAH_OFS) begin
      next_rdata = {16'h0000, sah};
    end else if (wb_adr_i == `NVM_PINCFG_OFS) begin
      next_rdata = {28'h000_0000, pincfg};
    end else begin
      next_rdata = 32'h0000_0000;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= req && !wb_ack_o;
      if (req && !wb_ack_o) begin
        wb_dat_o <= next_rdata;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------------------
  assign sh_op      = loading ? nvm_pkg::OP_READ : cmd_op;
  assign sh_loc     = loading ? {4'h0, idx} : cmd_loc;
  assign sh_pack    = build_word(sh_op, sh_loc, data);
  assign sh_start   = (state == nvm_pkg::ST_IDLE) &&
                      (loading || (cmd_busy && cmd_op != nvm_pkg::OP_RELOAD));
  assign self_timed = (cmd_op == nvm_pkg::OP_WRITE) || (cmd_op == nvm_pkg::OP_FILL) ||
                      (cmd_op == nvm_pkg::OP_ERASE) || (cmd_op == nvm_pkg::OP_WIPE);
  assign gap_end    = (state == nvm_pkg::ST_GAP) && (tcnt == 23'(HALF - 1));

  nvm_serial_shift u_shift (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .start_i  (sh_start),
    .nbits_i  (sh_pack[22:18]),
    .word_i   (sh_pack[17:0]),
    .din_i    (din_s),
    .done_o   (sh_done),
    .active_o (sh_active),
    .sk_o     (sh_sk),
    .dout_o   (sh_dout),
    .doe_o    (sh_doe),
    .rx_o     (rx)
  );

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state    <= nvm_pkg::ST_IDLE;
      loading  <= 1'b1;
      boot     <= 1'b1;
      idx      <= `NVM_SIG_LOC;
      cmd_busy <= 1'b0;
      cmd_op   <= nvm_pkg::OP_READ;
      cmd_loc  <= 7'h00;
      to_flag  <= 1'b0;
      loaded   <= 1'b0;
    end else begin
      if (cmd_wr && !busy_view) begin
        cmd_op  <= nvm_pkg::nvm_op_e'(nw[`NVM_OP_MSB:`NVM_OP_LSB]);
        cmd_loc <= nw[`NVM_LOC_MSB:0];
        // Writing one to the loaded bit clears loaded and the timeout flag, a start clears the timeout flag; a set below in the same cycle still wins
        if (nw[`NVM_LOADED_BIT] || nw[`NVM_BUSY_BIT]) begin
          to_flag <= 1'b0;
        end
        if (nw[`NVM_LOADED_BIT] && wb_sel_i[1]) begin
          loaded <= 1'b0;
        end
      end
      if (host_start) begin
        cmd_busy <= 1'b1;
      end
      case (state)
        nvm_pkg::ST_IDLE: begin
          if (sh_start) begin
            state <= nvm_pkg::ST_SHIFT;
          end else if (cmd_busy && cmd_op == nvm_pkg::OP_RELOAD) begin
            loading <= 1'b1;
            idx     <= `NVM_SIG_LOC;
            loaded  <= 1'b0;
          end
        end
        nvm_pkg::ST_SHIFT: begin
          if (sh_done) begin
            state <= nvm_pkg::ST_NEXT;
          end
        end
        nvm_pkg::ST_NEXT: begin
          state <= nvm_pkg::ST_IDLE;
          if (loading) begin
            if (idx == `NVM_SIG_LOC && rx != `NVM_SIGNATURE) begin
              loading  <= 1'b0;
              boot     <= 1'b0;
              cmd_busy <= 1'b0;
            end else if (idx == `NVM_ADDR_BYTES) begin
              loading  <= 1'b0;
              boot     <= 1'b0;
              cmd_busy <= 1'b0;
              loaded   <= 1'b1;
            end else begin
              idx <= idx + 3'h1;
            end
          end else if (self_timed) begin
            state <= nvm_pkg::ST_GAP;
          end else begin
            cmd_busy <= 1'b0;
          end
        end
        nvm_pkg::ST_GAP: begin
          if (gap_end) begin
            state <= nvm_pkg::ST_POLL;
          end
        end
        nvm_pkg::ST_POLL: begin
          // The synchroniser still shows the released line for a few cycles after select rises
          if (din_s && tcnt >= `NVM_POLL_SETTLE) begin
            cmd_busy <= 1'b0;
            state    <= nvm_pkg::ST_IDLE;
          end else if (tcnt == 23'(TIMEOUT_CYC - 1)) begin
            to_flag  <= 1'b1;
            cmd_busy <= 1'b0;
            state    <= nvm_pkg::ST_IDLE;
          end
        end
        default: begin
          state <= nvm_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // Gap and ready-wait counter; ready is polled with select raised again
  always_ff @(posedge clk_i) begin
    if (rst_i || state == nvm_pkg::ST_NEXT || gap_end) begin
      tcnt <= 23'h00_0000;
    end else if (state == nvm_pkg::ST_GAP || state == nvm_pkg::ST_POLL) begin
      tcnt <= tcnt + 23'h00_0001;
    end
  end

  // ---------------------------------------------------------------------------
  // Data, station address and pin configuration registers
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      data <= 8'h00;
    end else if (state == nvm_pkg::ST_NEXT && !loading && cmd_op == nvm_pkg::OP_READ) begin
      data <= rx;
    end else if (wr && wb_adr_i == `NVM_DATA_OFS && wb_sel_i[0] && !busy_view) begin
      data <= wb_dat_i[7:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sal <= 32'h0000_0000;
      sah <= 16'h0000;
    end else if (state == nvm_pkg::ST_NEXT && loading && idx != `NVM_SIG_LOC) begin
      // Location n lands in station address byte n-1
      case (idx)
        3'h1:    sal[7:0]   <= rx;
        3'h2:    sal[15:8]  <= rx;
        3'h3:    sal[23:16] <= rx;
        3'h4:    sal[31:24] <= rx;
        3'h5:    sah[7:0]   <= rx;
        default: sah[15:8]  <= rx;
      endcase
    end else if (wr && wb_adr_i == `NVM_SAL_OFS) begin
      sal <= lane_merge(sal, wb_dat_i, wb_sel_i);
    end else if (wr && wb_adr_i == `NVM_SAH_OFS) begin
      sah <= sah_merged[15:0];
    end
  end
  assign sah_merged     = lane_merge({16'h0000, sah}, wb_dat_i, wb_sel_i);
  assign station_addr_o = {sah, sal};

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pincfg <= 4'h0;
    end else if (wr && wb_adr_i == `NVM_PINCFG_OFS && wb_sel_i[0]) begin
      pincfg <= wb_dat_i[3:0];
    end
  end

  // ---------------------------------------------------------------------------
  // Pin drivers, registered so pins never glitch on decode changes
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      serial_mem_select_o      <= 1'b0;
      serial_mem_clock_pin_o   <= 1'b0;
      serial_mem_data_pin_o    <= 1'b0;
      serial_mem_data_pin_oe_o <= 1'b0;
    end else if (pincfg[`NVM_PIN_DIS_BIT]) begin
      serial_mem_select_o      <= 1'b0;
      serial_mem_data_pin_oe_o <= 1'b1;
      if (pincfg[`NVM_PIN_MON_BIT]) begin
        serial_mem_clock_pin_o <= mon_s[1];
        serial_mem_data_pin_o  <= mon_s[0];
      end else begin
        serial_mem_clock_pin_o <= pincfg[`NVM_PIN_GPC_BIT];
        serial_mem_data_pin_o  <= pincfg[`NVM_PIN_GPD_BIT];
      end
    end else begin
      serial_mem_select_o      <= sh_active || state == nvm_pkg::ST_POLL;
      serial_mem_clock_pin_o   <= sh_sk;
      serial_mem_data_pin_o    <= sh_dout;
      // Write data must be driven too; within a frame only reads hand the line to the memory
      serial_mem_data_pin_oe_o <= sh_doe || (sh_active && sh_op != nvm_pkg::OP_READ);
    end
  end

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  a_sig_absent_noload: assert property (@(posedge clk_i) disable iff (rst_i)
    (state == nvm_pkg::ST_NEXT && loading && idx == `NVM_SIG_LOC && rx != `NVM_SIGNATURE)
      |=> !loading && !loaded && !boot)
    else $error("missing signature did not end the load");

  a_six_bytes_loaded: assert property (@(posedge clk_i) disable iff (rst_i)
    (state == nvm_pkg::ST_NEXT && loading && idx == `NVM_ADDR_BYTES)
      |=> loaded && !loading && station_addr_o[47:40] == $past(rx))
    else $error("loaded flag or last address byte wrong");

  a_boot_blocks_host: assert property (@(posedge clk_i) disable iff (rst_i)
    boot |-> !cmd_busy && !host_start)
    else $error("host operation during start-up load");

  a_busy_start: assert property (@(posedge clk_i) disable iff (rst_i)
    host_start |=> cmd_busy && busy_view)
    else $error("busy not set by host start");

  a_read_into_data: assert property (@(posedge clk_i) disable iff (rst_i)
    (state == nvm_pkg::ST_NEXT && !loading && cmd_op == nvm_pkg::OP_READ)
      |=> data == $past(rx) && !cmd_busy)
    else $error("read byte missing when busy cleared");

  a_timeout_sets: assert property (@(posedge clk_i) disable iff (rst_i)
    (state == nvm_pkg::ST_POLL && !din_s && tcnt == 23'(TIMEOUT_CYC - 1))
      |=> to_flag && !cmd_busy && state == nvm_pkg::ST_IDLE)
    else $error("timeout not flagged");

  a_start_bit_first: assert property (@(posedge clk_i) disable iff (rst_i)
    sh_start |-> sh_pack[17] && (sh_pack[22:18] == `NVM_LEN_LONG) == (sh_op == nvm_pkg::OP_READ ||
      sh_op == nvm_pkg::OP_WRITE || sh_op == nvm_pkg::OP_FILL))
    else $error("bad command header or length");

  a_pins_released: assert property (@(posedge clk_i) disable iff (rst_i)
    pincfg[`NVM_PIN_DIS_BIT] && !pincfg[`NVM_PIN_MON_BIT]
      |=> !serial_mem_select_o && serial_mem_data_pin_o == $past(pincfg[`NVM_PIN_GPD_BIT]))
    else $error("pins not handed to general outputs");
endmodule // nvm_ctrl

// file: nvm_mem_model.sv
// Behavioural serial memory answering the controller's frames
`timescale 1ns/1ps
module nvm_mem_model (
  input  wire logic cs_i,
  input  wire logic sk_i,
  input  wire logic d_i,
  input  wire logic mute_i,
  output logic      q_o
);
  logic [7:0]  mem [128];
  logic [17:0] sr;
  logic [9:0]  hdr;
  logic        en;
  logic        pend;
  int          n;
  initial begin
    en = 0;
    pend = 0;
    n = 0;
    q_o = 0;
    foreach (mem[i]) mem[i] = 8'(i);
    mem[0] = 8'ha5;
  end
  always @(posedge sk_i) if (cs_i) begin
    sr = {sr[16:0], d_i};
    n++;
    if (n == 10) hdr = sr[9:0];
  end
  always @(negedge sk_i) if (cs_i && n >= 10 && n < 18 && hdr[8:7] == 2'b10) q_o = mem[hdr[6:0]][17-n];
  // A released line shows the inverse of its last level, never a held value
  always @(negedge cs_i) begin
    q_o = ~q_o;
    if (n >= 10) begin
      pend = hdr[8:7] != 2'b10 && !(hdr[8:7] == 2'b00 && hdr[6] == hdr[5]);
      if (hdr[8:5] == 4'b0011) en = 1;
      if (hdr[8:5] == 4'b0000) en = 0;
      if (en) case (hdr[8:7])
        2'b01: if (n == 18) mem[hdr[6:0]] = sr[7:0];
        2'b11: mem[hdr[6:0]] = 8'hff;
        2'b00: foreach (mem[i]) mem[i] = hdr[6:5] == 2'b01 ? sr[7:0] : hdr[6:5] == 2'b10 ? 8'hff : mem[i];
        default: ;
      endcase
    end
    n = 0;
  end
  // Muted, the memory never reports ready so the controller must give up
  always @(posedge cs_i) if (pend) begin
    q_o = ~mute_i;
    pend = 0;
  end
endmodule  // nvm_mem_model

// file: nvm_ctrl_test.sv
// Self-checking bench for the serial memory controller
`timescale 1ns/1ps
`include "nvm_ctrl_regs.svh"
module nvm_ctrl_test;
  typedef struct {logic [2:0] op; logic [6:0] loc; logic [7:0] dat; logic [7:0] exp;} row_s;
  logic        clk_i = 0, rst_i = 1, cyc = 0, we = 0, mute = 0;
  logic [7:0]  adr = 0;
  logic [31:0] wdat = 0, rdat, rd;
  logic        ack, cs, sk, dout, doe, q, din;
  logic [1:0]  mon = 0;
  logic [47:0] sta;
  int          n_errors = 0, n_checks = 0, nsk = 0, frame = 0;
  row_s rows [14] = '{'{3'h2, 7'h00, 8'h00, 8'h00}, '{3'h3, 7'h05, 8'h3c, 8'h00}, '{3'h0, 7'h05, 8'h00, 8'h3c},
    '{3'h5, 7'h05, 8'h00, 8'h00}, '{3'h0, 7'h05, 8'h00, 8'hff}, '{3'h1, 7'h00, 8'h00, 8'h00},
    '{3'h3, 7'h05, 8'h11, 8'h00}, '{3'h0, 7'h05, 8'h00, 8'hff}, '{3'h2, 7'h00, 8'h00, 8'h00},
    '{3'h4, 7'h00, 8'h5a, 8'h00}, '{3'h0, 7'h7f, 8'h00, 8'h5a}, '{3'h6, 7'h00, 8'h00, 8'h00},
    '{3'h0, 7'h00, 8'h00, 8'hff}, '{3'h7, 7'h00, 8'h00, 8'h00}};
  always #2.5 clk_i = ~clk_i;
  assign din = doe ? dout : q;
  always @(posedge sk) if (cs) nsk++;
  always @(negedge cs) begin
    if (nsk != 0) frame = nsk;
    nsk = 0;
  end
  nvm_ctrl #(.TIMEOUT_CYC(2000)) nvm_ctrl_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .serial_mem_select_o(cs), .serial_mem_clock_pin_o(sk), .serial_mem_data_pin_o(dout),
    .serial_mem_data_pin_oe_o(doe), .serial_mem_data_pin_i(din), .mii_mon_i(mon), .station_addr_o(sta));
  nvm_mem_model nvm_mem_model_inst (.cs_i(cs), .sk_i(sk), .d_i(din), .mute_i(mute), .q_o(q));
  task automatic chk(input string s, input logic [47:0] seen, input logic [47:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", s, exp, seen);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int t = 0;
    cyc <= 1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk_i);
      t++;
    end while (ack !== 1'b1 && t < 100);
    rd = rdat;
    if (t >= 100) n_errors++;
    cyc <= 0;
    @(posedge clk_i);
  endtask
  task automatic idle(input int lim);
    int t = 0;
    do begin
      bus(0, `NVM_CMD_OFS, 32'h0000_0000);
      t++;
    end while (rd[31] !== 1'b0 && t < lim);
    if (t >= lim) n_errors++;
  endtask
  task automatic end_of_test;
    if (n_errors == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 0;
    idle(20000);
    chk("loaded", rd[8], 1);
    chk("station", sta, 48'h0605_0403_0201);
    bus(0, `NVM_SAL_OFS, 32'h0000_0000);
    chk("addr_low", rd, 32'h0403_0201);
    foreach (rows[i]) begin
      bus(1, `NVM_DATA_OFS, {24'h0, rows[i].dat});
      bus(1, `NVM_CMD_OFS, {1'b1, rows[i].op, 21'h0, rows[i].loc});
      // A reload with the signature present would walk seven locations; here the wiped memory ends it at location 0
      idle(rows[i].op == 3'h7 ? 12000 : 3000);
      chk("timeout", rd[9], 0);
      chk("clocks", 48'(frame), rows[i].op inside {3'h0, 3'h3, 3'h4, 3'h7} ? 18 : 10);
      bus(0, `NVM_DATA_OFS, 32'h0000_0000);
      if (rows[i].op == 3'h0) chk("data", rd[7:0], rows[i].exp);
    end
    bus(0, `NVM_CMD_OFS, 32'h0000_0000);
    chk("reload", rd[8], 0);
    chk("kept", sta, 48'h0605_0403_0201);
    mute <= 1;
    bus(1, `NVM_CMD_OFS, 32'hd000_0001);
    idle(3000);
    chk("timeout", rd[9], 1);
    bus(0, 8'h20, 32'h0000_0000);
    chk("unmapped", rd, 32'h0000_0000);
    bus(1, `NVM_PINCFG_OFS, 32'h0000_0007);
    repeat (8) @(posedge clk_i);
    chk("gp_pins", {cs, sk, dout}, 3'b011);
    mon <= 2'b10;
    bus(1, `NVM_PINCFG_OFS, 32'h0000_0009);
    repeat (8) @(posedge clk_i);
    chk("mon_pins", {sk, dout}, 2'b10);
    end_of_test;
  end
  initial begin
    #550_000;
    n_errors++;
    end_of_test;
  end
endmodule  // nvm_ctrl_test
